// ---- rtl/acp_defs.svh ----
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define ACP_OFF_CFG      8'h00
`define ACP_OFF_PIN_LO   8'h04
`define ACP_OFF_PIN_MID  8'h08
`define ACP_OFF_RESULT   8'h0c

// Reset values
`define ACP_RST_CFG      8'h00
`define ACP_RST_PIN      8'h00

// Configuration field positions
`define ACP_CFG_LPC      7
`define ACP_CFG_DIV_HI   6
`define ACP_CFG_DIV_LO   5
`define ACP_CFG_LSMP     4
`define ACP_CFG_MODE_HI  3
`define ACP_CFG_MODE_LO  2
`define ACP_CFG_CLK_HI   1
`define ACP_CFG_CLK_LO   0

// Result status word field positions
`define ACP_RES_VALID    16

// AXI response codes
`define ACP_RESP_OKAY    2'b00
`define ACP_RESP_SLVERR  2'b10

`endif

// ---- rtl/acp_pkg.sv ----
package acp_pkg;

    // Converter input clock source
    typedef enum logic [1:0] {
        ACP_SRC_BUS      = 2'b00,
        ACP_SRC_BUS_HALF = 2'b01,
        ACP_SRC_ALT      = 2'b10,
        ACP_SRC_ASYNC    = 2'b11
    } acp_clksrc_e;

    // Result resolution codes; 01 and 11 are reserved
    typedef enum logic [1:0] {
        ACP_MODE_8BIT  = 2'b00,
        ACP_MODE_RSV1  = 2'b01,
        ACP_MODE_10BIT = 2'b10,
        ACP_MODE_RSV3  = 2'b11
    } acp_mode_e;

    // Converter configuration register layout, msb first
    typedef struct packed {
        logic        low_power_select;
        logic [1:0]  clock_divide_select;
        logic        long_sample_select;
        logic [1:0]  mode;
        logic [1:0]  input_clock_select;
    } acp_cfg_s;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        ACP_REG_CFG    = 3'b000,
        ACP_REG_PIN_LO = 3'b001,
        ACP_REG_PIN_MD = 3'b010,
        ACP_REG_RESULT = 3'b011,
        ACP_REG_NONE   = 3'b100
    } acp_reg_e;

endpackage

// ---- rtl/acp_clkdiv.sv ----
`timescale 1ns/1ps
`include "acp_defs.svh"

module acp_clkdiv #(
    parameter int CNT_W = 3                          // Divider counter width
) (
    input  wire logic             clk,               // Bus clock, 20 MHz
    input  wire logic             rst_n,             // Async reset, active low
    input  wire acp_pkg::acp_cfg_s cfg,              // Live configuration
    input  wire logic             alt_clk_pin,       // Alternate clock input
    input  wire logic             async_clk_pin,     // Internal async clock
    output logic                  conv_clk_en        // Converter clock pulse
);

    // Refuse counters too narrow for divide by 8
    if (CNT_W < 3) begin : g_chk
        $error("acp_clkdiv: CNT_W must be at least 3");
    end

    // Mask of counter bits that must be all ones per divide code
    function automatic logic [CNT_W-1:0] div_mask(input logic [1:0] code);
        logic [CNT_W-1:0] m;
        m = '0;
        unique case (code)
            2'b00: m = CNT_W'(3'h0);
            2'b01: m = CNT_W'(3'h1);
            2'b10: m = CNT_W'(3'h3);
            2'b11: m = CNT_W'(3'h7);
        endcase
        return m;
    endfunction

    logic [2:0]       alt_sync_reg,   alt_sync_next;    // Alt sync and edge stage
    logic [2:0]       asy_sync_reg,   asy_sync_next;    // Async sync and edge stage
    logic             half_reg,       half_next;        // Bus clock halving toggle
    logic [CNT_W-1:0] cnt_reg,        cnt_next;         // Divider count
    logic             en_reg,         en_next;          // Registered output pulse
    logic             src_pulse;                        // Selected source tick
    logic [CNT_W-1:0] mask;                             // Current divide mask

    // Source select and divide; foreign clocks are only seen as edges
    always_comb begin
        alt_sync_next = {alt_sync_reg[1:0], alt_clk_pin};
        asy_sync_next = {asy_sync_reg[1:0], async_clk_pin};
        half_next     = ~half_reg;
        mask          = div_mask(cfg.clock_divide_select);
        src_pulse     = 1'b0;
        unique case (acp_pkg::acp_clksrc_e'(cfg.input_clock_select))
            acp_pkg::ACP_SRC_BUS:      src_pulse = 1'b1;
            acp_pkg::ACP_SRC_BUS_HALF: src_pulse = half_reg;
            // Edge taken between 2nd and 3rd stage, 1st stage left alone
            acp_pkg::ACP_SRC_ALT:      src_pulse = alt_sync_reg[1] & ~alt_sync_reg[2];
            acp_pkg::ACP_SRC_ASYNC:    src_pulse = asy_sync_reg[1] & ~asy_sync_reg[2];
        endcase
        cnt_next = cnt_reg;
        en_next  = 1'b0;
        if (src_pulse) begin
            cnt_next = cnt_reg + CNT_W'(1);
            en_next  = ((cnt_reg & mask) == mask);
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_sync_reg <= 3'h0;
            asy_sync_reg <= 3'h0;
            half_reg     <= 1'b0;
            cnt_reg      <= '0;
            en_reg       <= 1'b0;
        end else begin
            alt_sync_reg <= alt_sync_next;
            asy_sync_reg <= asy_sync_next;
            half_reg     <= half_next;
            cnt_reg      <= cnt_next;
            en_reg       <= en_next;
        end
    end

    assign conv_clk_en = en_reg;

endmodule

// ---- rtl/acp_top.sv ----
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "acp_defs.svh"

module acp_top #(
    parameter int ADDR_W    = 8,                      // AXI address width
    parameter int PIN_COUNT = 16                      // Governed analog pins
) (
    input  wire logic                 clk,            // Bus clock, 20 MHz
    input  wire logic                 rst_n,          // Async reset, active low
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,   // Write address
    input  wire logic                 s_axi_awvalid,  // Write address valid
    output logic                      s_axi_awready,  // Write address ready
    input  wire logic [31:0]          s_axi_wdata,    // Write data
    input  wire logic [3:0]           s_axi_wstrb,    // Write byte enables
    input  wire logic                 s_axi_wvalid,   // Write data valid
    output logic                      s_axi_wready,   // Write data ready
    output logic [1:0]                s_axi_bresp,    // Write response
    output logic                      s_axi_bvalid,   // Write response valid
    input  wire logic                 s_axi_bready,   // Write response ready
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,   // Read address
    input  wire logic                 s_axi_arvalid,  // Read address valid
    output logic                      s_axi_arready,  // Read address ready
    output logic [31:0]               s_axi_rdata,    // Read data
    output logic [1:0]                s_axi_rresp,    // Read response
    output logic                      s_axi_rvalid,   // Read data valid
    input  wire logic                 s_axi_rready,   // Read data ready
    // Converter clock inputs from outside this domain
    input  wire logic                 alt_clk_pin,    // Alternate clock input
    input  wire logic                 async_clk_pin,  // Internal async clock
    // Converter side
    input  wire logic [9:0]           conv_result,    // Raw conversion result
    input  wire logic                 conv_done,      // Result strobe, 1 cycle
    output logic                      low_power_select,   // Low power mode
    output logic                      long_sample_select, // Long sample time
    output logic                      mode_10bit,     // 10-bit resolution
    output logic                      conv_clk_en,    // Converter clock pulse
    output logic [9:0]                result_data,    // Held result
    output logic                      result_valid,   // Held result valid
    // Port and pad side
    input  wire logic [PIN_COUNT-1:0] port_out,       // Port output values
    input  wire logic [PIN_COUNT-1:0] port_oe,        // Port output enables
    input  wire logic [PIN_COUNT-1:0] port_pullup,    // Port pullup enables
    input  wire logic [PIN_COUNT-1:0] pad_in,         // Pad input levels
    output logic [PIN_COUNT-1:0]      pad_out,        // Pad output values
    output logic [PIN_COUNT-1:0]      pad_oe,         // Pad output enables
    output logic [PIN_COUNT-1:0]      pad_pullup,     // Pad pullup enables
    output logic [PIN_COUNT-1:0]      port_read,      // Port read values
    output logic [PIN_COUNT-1:0]      analog_select   // Pin handed to analog
);

    // Only two 8-bit pin registers exist
    if (PIN_COUNT != 16) begin : g_chk_pins
        $error("acp_top: PIN_COUNT must be 16");
    end
    if (ADDR_W < 4) begin : g_chk_addr
        $error("acp_top: ADDR_W must be at least 4");
    end

    // Address decode shared by both channels; low two bits ignored
    function automatic acp_pkg::acp_reg_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        if (w == ADDR_W'(`ACP_OFF_CFG))
            return acp_pkg::ACP_REG_CFG;
        else if (w == ADDR_W'(`ACP_OFF_PIN_LO))
            return acp_pkg::ACP_REG_PIN_LO;
        else if (w == ADDR_W'(`ACP_OFF_PIN_MID))
            return acp_pkg::ACP_REG_PIN_MD;
        else if (w == ADDR_W'(`ACP_OFF_RESULT))
            return acp_pkg::ACP_REG_RESULT;
        else
            return acp_pkg::ACP_REG_NONE;
    endfunction

    // Bus channel state
    logic              aw_hold_reg,  aw_hold_next;    // Write address held
    logic [ADDR_W-1:0] aw_addr_reg,  aw_addr_next;    // Held write address
    logic              w_hold_reg,   w_hold_next;     // Write data held
    logic [7:0]        w_data_reg,   w_data_next;     // Held low data byte
    logic              w_strb_reg,   w_strb_next;     // Held lane 0 enable
    logic              bvalid_reg,   bvalid_next;     // Write response valid
    logic [1:0]        bresp_reg,    bresp_next;      // Write response code
    logic              rvalid_reg,   rvalid_next;     // Read data valid
    logic [1:0]        rresp_reg,    rresp_next;      // Read response code
    logic [31:0]       rdata_reg,    rdata_next;      // Read data word
    // Register file
    acp_pkg::acp_cfg_s cfg_reg,      cfg_next;        // Converter configuration
    logic [7:0]        pin_lo_reg,   pin_lo_next;     // Channels 0..7 control
    logic [7:0]        pin_md_reg,   pin_md_next;     // Channels 8..15 control
    logic [9:0]        res_reg,      res_next;        // Held result
    logic              res_vld_reg,  res_vld_next;    // Held result valid
    // Pad path
    logic [PIN_COUNT-1:0] pad_s1_reg;                 // Pad sync, first stage
    logic [PIN_COUNT-1:0] pad_s2_reg;                 // Pad sync, second stage
    logic [PIN_COUNT-1:0] pad_out_reg,  pad_out_next; // Registered pad value
    logic [PIN_COUNT-1:0] pad_oe_reg,   pad_oe_next;  // Registered pad enable
    logic [PIN_COUNT-1:0] pad_pu_reg,   pad_pu_next;  // Registered pullup
    logic [PIN_COUNT-1:0] port_rd_reg,  port_rd_next; // Registered port read
    // Helpers
    logic              aw_take;                       // Address taken this edge
    logic              w_take;                        // Data taken this edge
    logic              ar_take;                       // Read taken this edge
    logic              do_write;                      // Write commits this edge
    logic [ADDR_W-1:0] wr_addr;                       // Effective write address
    logic [7:0]        wr_byte;                       // Effective write byte
    logic              wr_lane0;                      // Effective lane 0 enable
    logic              mode_change;                   // Resolution field written with a new value
    logic [PIN_COUNT-1:0] ctl;                        // Combined pin control

    // Accept address and data independently, one write at a time
    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign wr_addr       = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_byte       = w_hold_reg ? w_data_reg : s_axi_wdata[7:0];
    assign wr_lane0      = w_hold_reg ? w_strb_reg : s_axi_wstrb[0];
    assign do_write      = (aw_hold_reg | aw_take) & (w_hold_reg | w_take);

    // Write channel and register file next values
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        cfg_next     = cfg_reg;
        pin_lo_next  = pin_lo_reg;
        pin_md_next  = pin_md_reg;
        mode_change  = 1'b0;
        if (aw_take) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (w_take) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_strb_next = s_axi_wstrb[0];
        end
        // Response retires before the next write is accepted
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `ACP_RESP_OKAY;
            unique case (reg_sel(wr_addr))
                acp_pkg::ACP_REG_CFG: begin
                    if (wr_lane0) begin
                        cfg_next    = acp_pkg::acp_cfg_s'(wr_byte);
                        mode_change = (wr_byte[`ACP_CFG_MODE_HI:`ACP_CFG_MODE_LO]
                                       != cfg_reg.mode);
                    end
                end
                acp_pkg::ACP_REG_PIN_LO: begin
                    if (wr_lane0) begin
                        pin_lo_next = wr_byte;
                    end
                end
                acp_pkg::ACP_REG_PIN_MD: begin
                    if (wr_lane0) begin
                        pin_md_next = wr_byte;
                    end
                end
                // Result word is read-only; writes are ignored
                acp_pkg::ACP_REG_RESULT: bresp_next = `ACP_RESP_OKAY;
                acp_pkg::ACP_REG_NONE:   bresp_next = `ACP_RESP_SLVERR;
            endcase
        end
    end

    // Result holding; a new result beats a same-cycle invalidation
    always_comb begin
        res_next     = res_reg;
        res_vld_next = res_vld_reg;
        if (mode_change) begin
            res_vld_next = 1'b0;
        end
        if (conv_done) begin
            res_vld_next = 1'b1;
            // Reserved codes are served as 8-bit, the safe narrower form
            if (cfg_reg.mode == acp_pkg::ACP_MODE_10BIT) begin
                res_next = conv_result;
            end else begin
                res_next = {2'b00, conv_result[7:0]};
            end
        end
    end

    // Read channel; data registered so rdata is stable while rvalid
    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (ar_take) begin
            rvalid_next = 1'b1;
            rresp_next  = `ACP_RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            unique case (reg_sel(s_axi_araddr))
                acp_pkg::ACP_REG_CFG:    rdata_next[7:0] = cfg_reg;
                acp_pkg::ACP_REG_PIN_LO: rdata_next[7:0] = pin_lo_reg;
                acp_pkg::ACP_REG_PIN_MD: rdata_next[7:0] = pin_md_reg;
                acp_pkg::ACP_REG_RESULT: begin
                    rdata_next[9:0]                = res_reg;
                    rdata_next[`ACP_RES_VALID]     = res_vld_reg;
                end
                acp_pkg::ACP_REG_NONE:   rresp_next = `ACP_RESP_SLVERR;
            endcase
        end
    end

    // Pad override; costs one cycle of latency on every pad path
    assign ctl = {pin_md_reg, pin_lo_reg};
    always_comb begin
        pad_out_next = port_out & ~ctl;
        pad_oe_next  = port_oe & ~ctl;
        pad_pu_next  = port_pullup & ~ctl;
        port_rd_next = pad_s2_reg & ~ctl;
    end

    // Bus and register file state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `ACP_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `ACP_RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            cfg_reg     <= `ACP_RST_CFG;
            pin_lo_reg  <= `ACP_RST_PIN;
            pin_md_reg  <= `ACP_RST_PIN;
            res_reg     <= 10'h000;
            res_vld_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            cfg_reg     <= cfg_next;
            pin_lo_reg  <= pin_lo_next;
            pin_md_reg  <= pin_md_next;
            res_reg     <= res_next;
            res_vld_reg <= res_vld_next;
        end
    end

    // Pad state; pad inputs synchronised before anything reads them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1_reg  <= '0;
            pad_s2_reg  <= '0;
            pad_out_reg <= '0;
            pad_oe_reg  <= '0;
            pad_pu_reg  <= '0;
            port_rd_reg <= '0;
        end else begin
            pad_s1_reg  <= pad_in;
            pad_s2_reg  <= pad_s1_reg;
            pad_out_reg <= pad_out_next;
            pad_oe_reg  <= pad_oe_next;
            pad_pu_reg  <= pad_pu_next;
            port_rd_reg <= port_rd_next;
        end
    end

    // Converter clock source select and divider
    acp_clkdiv #(
        .CNT_W (3)
    ) u_clkdiv (
        .clk           (clk),
        .rst_n         (rst_n),
        .cfg           (cfg_reg),
        .alt_clk_pin   (alt_clk_pin),
        .async_clk_pin (async_clk_pin),
        .conv_clk_en   (conv_clk_en)
    );

    // Outputs
    assign s_axi_bvalid       = bvalid_reg;
    assign s_axi_bresp        = bresp_reg;
    assign s_axi_rvalid       = rvalid_reg;
    assign s_axi_rresp        = rresp_reg;
    assign s_axi_rdata        = rdata_reg;
    assign low_power_select   = cfg_reg.low_power_select;
    assign long_sample_select = cfg_reg.long_sample_select;
    assign mode_10bit         = (cfg_reg.mode == acp_pkg::ACP_MODE_10BIT);
    assign result_data        = res_reg;
    assign result_valid       = res_vld_reg;
    assign pad_out            = pad_out_reg;
    assign pad_oe             = pad_oe_reg;
    assign pad_pullup         = pad_pu_reg;
    assign port_read          = port_rd_reg;
    assign analog_select      = ctl;

endmodule

// ---- tb/acp_top_chk.sv ----
`timescale 1ns/1ps
module acp_top_chk #(
    parameter int PIN_COUNT = 16                    // Governed pins
) (
    input wire logic                 clk,           // Bus clock
    input wire logic                 rst_n,         // Async reset
    input wire logic                 s_axi_bvalid,  // Write answer
    input wire logic                 s_axi_bready,  // Answer taken
    input wire logic                 s_axi_arvalid, // Read request
    input wire logic                 s_axi_arready, // Read accepted
    input wire logic                 s_axi_rvalid,  // Read answer
    input wire logic                 s_axi_rready,  // Read taken
    input wire logic                 conv_done,     // Result strobe
    input wire logic [9:0]           conv_result,   // Raw result
    input wire logic                 mode_10bit,    // Resolution
    input wire logic [9:0]           result_data,   // Held result
    input wire logic                 result_valid,  // Held valid
    input wire logic [PIN_COUNT-1:0] port_oe,       // Port enables
    input wire logic [PIN_COUNT-1:0] pad_oe,        // Pad enables
    input wire logic [PIN_COUNT-1:0] port_out,      // Port values
    input wire logic [PIN_COUNT-1:0] pad_out,       // Pad values
    input wire logic [PIN_COUNT-1:0] port_pullup,   // Port pullups
    input wire logic [PIN_COUNT-1:0] pad_pullup,    // Pad pullups
    input wire logic [PIN_COUNT-1:0] port_read,     // Port read back
    input wire logic [PIN_COUNT-1:0] analog_select  // Analog pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Bus answers stand until taken; a read is answered on the next edge
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    // Result capture; upper bits masked outside 10-bit mode
    property p_conv; conv_done |=> result_valid && result_data ==
        $past({conv_result[9:8] & {2{mode_10bit}}, conv_result[7:0]}); endproperty
    a_conv: assert property (p_conv) else $error("result capture wrong");
    property p_8bit; result_valid && !mode_10bit |-> result_data[9:8] == 2'b00; endproperty
    a_8bit: assert property (p_8bit) else $error("upper bits in 8-bit");
    // Pad gating lags the control bits by one edge
    property p_pad; $past(rst_n) |-> pad_oe == $past(port_oe & ~analog_select); endproperty
    a_pad: assert property (p_pad) else $error("pad enable not gated");
    property p_pu; $past(rst_n) |-> pad_pullup == $past(port_pullup & ~analog_select) &&
        pad_out == $past(port_out & ~analog_select); endproperty
    a_pu: assert property (p_pu) else $error("pad pullup or value not gated");
    property p_read; $past(rst_n) |-> (port_read & $past(analog_select)) == '0; endproperty
    a_read: assert property (p_read) else $error("port read not zero");
    // Pin control moves only with a committed write
    property p_sel; $changed(analog_select) |-> s_axi_bvalid; endproperty
    a_sel: assert property (p_sel) else $error("pin control moved alone");
    c_conv10: cover property (conv_done && mode_10bit);
    c_pin: cover property (|analog_select);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind acp_top acp_top_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (.*);

// ---- tb/adc_config_and_pin_control_tb_top.sv ----
`timescale 1ns/1ps
`include "acp_defs.svh"
module adc_config_and_pin_control_tb_top;
    logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;      // Strobes
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;   // Handshakes
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done;       // Handshakes
    logic        alt_clk_pin, async_clk_pin, low_power_select, result_valid; // Misc
    logic        long_sample_select, mode_10bit, conv_clk_en;                // Controls
    logic [7:0]  s_axi_awaddr, s_axi_araddr;                                 // Addresses
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rs, d, r;                   // Data, random
    logic [3:0]  s_axi_wstrb;                                                // Enables
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;                             // Responses
    logic [9:0]  conv_result, result_data;                                   // Converter
    logic [15:0] port_out, port_oe, port_pullup, pad_in, pad_out, pad_oe;    // Pins
    logic [15:0] pad_pullup, port_read, analog_select;                       // Pins
    logic [7:0]  offs [3] = '{`ACP_OFF_CFG, `ACP_OFF_PIN_LO, `ACP_OFF_PIN_MID};
    int          err_total, n_compared, i, t;                                // Counters
    acp_top DUT (.*);
    always #25 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected {low power, long sample, 10-bit} from a config byte
    function automatic logic [2:0] exp_cfg(input logic [7:0] c);
        return {c[7], c[4], c[3:2] == 2'b10};
    endfunction
    // Pin side churns every cycle so gating is always exercised
    always @(posedge clk) begin
        rs <= lfsr(rs);
        {port_out, port_oe} <= rs;
        {port_pullup, pad_in} <= ~rs;
        {alt_clk_pin, async_clk_pin} <= rs[3:2];
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        r = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("compared=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog: whole run is near 500 cycles
    initial begin
        #500000;
        err_total++;
        print_verdict();
    end
    initial begin
        {clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, conv_done, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, conv_result} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'hb173c2bf;
        rs = seed;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 3; i++) begin
            rd(offs[i]);
            chk(r, 32'h0);
        end
        $display("reset test done");
        // Random bytes, noise above bit 7; cfg sees every mode and source code
        for (i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            d = {seed[31:4], 4'(i)};
            wr(offs[i % 3], d);
            chk(resp, `ACP_RESP_OKAY);
            rd(offs[i % 3]);
            chk(r, {24'h0, d[7:0]});
            if (i % 3 == 0) chk({low_power_select, long_sample_select, mode_10bit},
                exp_cfg(d[7:0]));
            else chk(analog_select[8 * (i % 3 - 1) +: 8], d[7:0]);
        end
        $display("register test done");
        wr(8'h10, 32'hff);
        chk(resp, `ACP_RESP_SLVERR);
        rd(8'h10);
        chk(r, 32'h0);
        chk(resp, `ACP_RESP_SLVERR);
        // Divider period on bus and half-bus sources; skip the early first pulse
        for (i = 0; i < 8; i++) begin
            wr(`ACP_OFF_CFG, {25'h0, 2'(i), 4'h0, i[2]});
            repeat (2) @(posedge clk iff conv_clk_en);
            t = 0;
            do begin @(posedge clk); t++; end while (!conv_clk_en);
            chk(t, (1 << i[1:0]) << i[2]);
        end
        $display("divider test done");
        // Result in 8-bit then 10-bit; the mode change must drop the old result
        for (i = 0; i < 2; i++) begin
            wr(`ACP_OFF_CFG, 32'(i * 8));
            chk(result_valid, 1'b0);
            conv_result <= 10'h2a5;
            conv_done <= 1'b1;
            @(posedge clk);
            conv_done <= 1'b0;
            @(posedge clk);
            rd(`ACP_OFF_RESULT);
            chk(r, i ? 32'h0001_02a5 : 32'h0001_00a5);
        end
        $display("result test done");
        print_verdict();
    end
endmodule
